// ===== inc/cssp_pkg.sv
// Purpose: Shared constants and carrier types for the servo and status pins.
// Assumes: One clock domain; all pin inputs are synchronous to clk.
// Notes:   Reset values mirror the pin states after system reset; processor reset forces all but clock, gain select and audio mute.
package cssp_pkg;

    // Subsystem clock division from the system clock.
    localparam int unsigned SUBCLK_DIV      = 128;
    localparam int unsigned SUBCLK_HALF     = SUBCLK_DIV / 2;
    localparam int unsigned SUBCLK_CNT_W    = $clog2(SUBCLK_HALF);

    // Output levels loaded by the system reset; the processor reset forces all but the clock, gain select and audio mute.
    localparam logic RST_SUBCLK        = 1'h0;
    localparam logic RST_RW_IND_N      = 1'h0;
    localparam logic RST_SYNC_MATCH    = 1'h0;
    localparam logic RST_CMD_STROBE    = 1'h0;
    localparam logic RST_CMD_DATA      = 1'h1;
    localparam logic RST_CMD_CLK_N     = 1'h1;
    localparam logic RST_SLED          = 1'h0;
    localparam logic RST_DRV_MUTE_N    = 1'h0;
    localparam logic RST_AUD_MUTE_N    = 1'h0;
    localparam logic RST_GAIN_SEL      = 1'h1;
    localparam logic RST_TRI_LEVEL     = 1'h0;
    localparam logic TRI_OE_OFF        = 1'h1;
    localparam logic TRI_OE_ON         = 1'h0;

    // Two-sided motor request for a three-state drive pin.
    typedef struct packed {
        logic accel;
        logic decel;
    } cssp_drive_req_type;

    // Track jump request with the direction of travel.
    typedef struct packed {
        logic accel;
        logic decel;
        logic outward;
    } cssp_jump_req_type;

    // Serial command port pins.
    typedef struct packed {
        logic writeStrobe;
        logic serialOut;
        logic shiftClockN;
    } cssp_cmd_type;

    // Sled feed pin pair.
    typedef struct packed {
        logic pos;
        logic neg;
    } cssp_sled_type;

endpackage

// ===== rtl/cssp_clk_div.sv
// Purpose: Divides the system clock down to the subsystem clock output.
// Assumes: Free running apart from the clock enable and the system reset.
// Notes:   The processor reset pin does not reach this divider.
module cssp_clk_div #(
    parameter int unsigned DIV = cssp_pkg::SUBCLK_DIV
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // Divided clock
    output logic      subClk
);

    localparam int unsigned HALF  = DIV / 2;
    localparam int unsigned CNT_W = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF - 1);

    logic [CNT_W-1:0] count_q;
    logic             subClk_q;

    // Half-period counter; the output toggles on its wrap.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= '0;
        end else if (ce) begin
            if (count_q == LAST) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            subClk_q <= cssp_pkg::RST_SUBCLK;
        end else if (ce && count_q == LAST) begin
            subClk_q <= ~subClk_q;
        end
    end

    assign subClk = subClk_q;

    a_subclk_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && count_q != LAST) |=> $stable(subClk_q)
    ) else $error("Subsystem clock changed inside a half period.");

    a_subclk_toggle: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && count_q == LAST) |=> (subClk_q != $past(subClk_q))
    ) else $error("Subsystem clock missed its toggle.");

endmodule

// ===== rtl/cssp_top.sv
// Purpose: Servo, status and command pins of the disc signal processor.
// Assumes: Pin inputs synchronous to clk; processor reset sampled on clk.
// Notes:   Processor reset takes effect at the first enabled edge.
module cssp_top #(
    parameter int unsigned SUBCLK_DIV = cssp_pkg::SUBCLK_DIV
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         ce,
    // Reset pins
    input  wire logic                         processorResetN,
    input  wire logic                         tunerResetN,
    // Disc and sync status
    input  wire logic                         discIsRw,
    input  wire logic                         syncDetected,
    input  wire logic                         syncInternal,
    // Servo requests
    input  wire cssp_pkg::cssp_drive_req_type spindleReq,
    input  wire cssp_pkg::cssp_jump_req_type  jumpReq,
    input  wire logic                         trackingOn,
    input  wire logic                         gainIncrease,
    input  wire cssp_pkg::cssp_sled_type      sledReq,
    // Command port and mutes
    input  wire cssp_pkg::cssp_cmd_type       cmdReq,
    input  wire logic                         driverMuteReq,
    input  wire logic                         audioMuteReq,
    // Clock and status pins
    output logic                              subsysClk,
    output logic                              rewritableDiscIndN,
    output logic                              frameSyncMatch,
    // Three-state servo pins
    output logic                              spindleDrive,
    output logic                              spindleDriveOeN,
    output logic                              trackJumpDrive,
    output logic                              trackJumpDriveOeN,
    output logic                              trackingDisable,
    output logic                              trackingDisableOeN,
    // Two-state servo pins
    output logic                              trackingGainSelect,
    output cssp_pkg::cssp_sled_type           sledFeed,
    // Command port and mutes
    output cssp_pkg::cssp_cmd_type            cmdOut,
    output logic                              driverMuteN,
    output logic                              audioMuteN
);

    logic                    procRst;
    logic                    jumpHigh;
    logic                    jumpLow;
    logic                    rwIndN_q;
    logic                    syncMatch_q;
    logic                    gainSel_q;
    cssp_pkg::cssp_sled_type sled_q;
    cssp_pkg::cssp_cmd_type  cmd_q;
    logic                    drvMuteN_q;
    logic                    audMuteN_q;

    // Outputs ignore the tuner reset; only the processor reset forces pins.
    assign procRst = ~processorResetN;

    // High accelerates outward or decelerates inward; low is the converse.
    assign jumpHigh = (jumpReq.accel & jumpReq.outward)
                    | (jumpReq.decel & ~jumpReq.outward);
    assign jumpLow  = (jumpReq.decel & jumpReq.outward)
                    | (jumpReq.accel & ~jumpReq.outward);

    // Subsystem clock keeps running through processor reset.
    cssp_clk_div #(
        .DIV (SUBCLK_DIV)
    ) uClkDiv (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .subClk  (subsysClk)
    );

    cssp_tri_out uSpindle (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .off       (procRst),
        .driveHigh (spindleReq.accel),
        .driveLow  (spindleReq.decel),
        .level     (spindleDrive),
        .oeN       (spindleDriveOeN)
    );

    cssp_tri_out uJump (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .off       (procRst),
        .driveHigh (jumpHigh),
        .driveLow  (jumpLow),
        .level     (trackJumpDrive),
        .oeN       (trackJumpDriveOeN)
    );

    cssp_tri_out uTrackOff (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .off       (procRst),
        .driveHigh (~trackingOn),
        .driveLow  (trackingOn),
        .level     (trackingDisable),
        .oeN       (trackingDisableOeN)
    );

    // Disc type indicator.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rwIndN_q <= cssp_pkg::RST_RW_IND_N;
        end else if (ce) begin
            if (procRst) begin
                rwIndN_q <= cssp_pkg::RST_RW_IND_N;
            end else begin
                rwIndN_q <= ~discIsRw;
            end
        end
    end

    // Frame sync coincidence monitor.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncMatch_q <= cssp_pkg::RST_SYNC_MATCH;
        end else if (ce) begin
            if (procRst) begin
                syncMatch_q <= cssp_pkg::RST_SYNC_MATCH;
            end else begin
                syncMatch_q <= syncDetected & syncInternal;
            end
        end
    end

    // Tracking gain select; system reset loads it high and the processor reset leaves it alone.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gainSel_q <= cssp_pkg::RST_GAIN_SEL;
        end else if (ce) begin
            gainSel_q <= ~gainIncrease;
        end
    end

    // Sled feed pair.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sled_q.pos <= cssp_pkg::RST_SLED;
            sled_q.neg <= cssp_pkg::RST_SLED;
        end else if (ce) begin
            if (procRst) begin
                sled_q.pos <= cssp_pkg::RST_SLED;
                sled_q.neg <= cssp_pkg::RST_SLED;
            end else begin
                sled_q <= sledReq;
            end
        end
    end

    // Serial command port.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q.writeStrobe <= cssp_pkg::RST_CMD_STROBE;
            cmd_q.serialOut   <= cssp_pkg::RST_CMD_DATA;
            cmd_q.shiftClockN <= cssp_pkg::RST_CMD_CLK_N;
        end else if (ce) begin
            if (procRst) begin
                cmd_q.writeStrobe <= cssp_pkg::RST_CMD_STROBE;
                cmd_q.serialOut   <= cssp_pkg::RST_CMD_DATA;
                cmd_q.shiftClockN <= cssp_pkg::RST_CMD_CLK_N;
            end else begin
                cmd_q <= cmdReq;
            end
        end
    end

    // Driver mute, active low.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            drvMuteN_q <= cssp_pkg::RST_DRV_MUTE_N;
        end else if (ce) begin
            if (procRst) begin
                drvMuteN_q <= cssp_pkg::RST_DRV_MUTE_N;
            end else begin
                drvMuteN_q <= ~driverMuteReq;
            end
        end
    end

    // Audio mute, active low.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            audMuteN_q <= cssp_pkg::RST_AUD_MUTE_N;
        end else if (ce) begin
            audMuteN_q <= ~audioMuteReq;
        end
    end

    assign rewritableDiscIndN = rwIndN_q;
    assign frameSyncMatch     = syncMatch_q;
    assign trackingGainSelect = gainSel_q;
    assign sledFeed           = sled_q;
    assign cmdOut             = cmd_q;
    assign driverMuteN        = drvMuteN_q;
    assign audioMuteN         = audMuteN_q;

    a_rw_indicator: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce |=> (rewritableDiscIndN == ($past(processorResetN)
                                      & ~$past(discIsRw)))
    ) else $error("Rewritable indicator level wrong.");

    a_sync_match: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !(processorResetN && syncDetected && syncInternal))
        |=> !frameSyncMatch
    ) else $error("Sync match high without coinciding syncs.");

    a_sync_hit: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && processorResetN && syncDetected && syncInternal)
        |=> frameSyncMatch
    ) else $error("Sync match missed a coincidence.");

    a_spindle_float: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && (procRst || spindleReq.accel == spindleReq.decel))
        |=> spindleDriveOeN
    ) else $error("Spindle pin driven while it should float.");

    a_spindle_drive: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !procRst && spindleReq.accel != spindleReq.decel)
        |=> (!spindleDriveOeN && spindleDrive == $past(spindleReq.accel))
    ) else $error("Spindle pin level wrong.");

    a_jump_level: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !procRst && jumpReq.accel && !jumpReq.decel)
        |=> (!trackJumpDriveOeN
             && trackJumpDrive == $past(jumpReq.outward))
    ) else $error("Track jump level wrong for acceleration.");

    a_jump_decel: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !procRst && jumpReq.decel && !jumpReq.accel)
        |=> (!trackJumpDriveOeN
             && trackJumpDrive == !$past(jumpReq.outward))
    ) else $error("Track jump level wrong for deceleration.");

    a_jump_reset: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && procRst) |=> trackJumpDriveOeN
    ) else $error("Track jump pin driven during reset.");

    a_track_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce |=> (trackingDisableOeN == $past(procRst)
                && ($past(procRst)
                    || trackingDisable == !$past(trackingOn)))
    ) else $error("Tracking disable pin wrong.");

    a_gain_select: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && gainIncrease) |=> !trackingGainSelect
    ) else $error("Gain select not low for gain increase.");

    a_gain_normal: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !gainIncrease) |=> trackingGainSelect
    ) else $error("Gain select low without a gain request.");

    a_cmd_reset: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && procRst) |=> (!cmdOut.writeStrobe && cmdOut.serialOut
                             && cmdOut.shiftClockN)
    ) else $error("Command port not idle during reset.");

    a_sled_reset: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && procRst) |=> (!sledFeed.pos && !sledFeed.neg)
    ) else $error("Sled outputs not low during reset.");

    a_driver_mute: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && (procRst || driverMuteReq)) |=> !driverMuteN
    ) else $error("Driver not muted.");

    a_audio_mute: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && audioMuteReq) |=> !audioMuteN
    ) else $error("Audio mute pin not low in mute mode.");

    a_freeze_state: assert property (
        @(posedge clk) disable iff (sys_rst)
        !ce |=> ($stable(cmdOut) && $stable(sledFeed)
                 && $stable(frameSyncMatch))
    ) else $error("Outputs changed while clock enable low.");

    a_tuner_ignored: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !tunerResetN && !procRst) |=> !trackingDisableOeN
    ) else $error("Tuner reset changed the tracking pin.");

endmodule

// ===== rtl/cssp_tri_out.sv
// Purpose: Registered three-state motor drive pin.
// Assumes: Requests are synchronous; off forces the pin to high impedance.
// Notes:   Both requests at once leave the pin floating.
module cssp_tri_out (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // Control
    input  wire logic off,
    input  wire logic driveHigh,
    input  wire logic driveLow,
    // Pin
    output logic      level,
    output logic      oeN
);

    logic level_q;
    logic oeN_q;

    // Drive high or low on a single request, float otherwise.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_q <= cssp_pkg::RST_TRI_LEVEL;
            oeN_q   <= cssp_pkg::TRI_OE_OFF;
        end else if (ce) begin
            if (off || (driveHigh == driveLow)) begin
                level_q <= cssp_pkg::RST_TRI_LEVEL;
                oeN_q   <= cssp_pkg::TRI_OE_OFF;
            end else begin
                level_q <= driveHigh;
                oeN_q   <= cssp_pkg::TRI_OE_ON;
            end
        end
    end

    assign level = level_q;
    assign oeN   = oeN_q;

endmodule

// ===== verif/cssp_servo_model.sv
// Purpose: Servo driver side of the three-state drive pins.
// Assumes: No pull resistors on the spindle, jump and tracking lines.
// Notes:   A floating line shows the inverse of its last driven level.
module cssp_servo_model (
    // Clock
    input  wire logic       clk,
    // Pins from the device, bit 2 spindle, bit 1 jump, bit 0 tracking
    input  wire logic [2:0] level,
    input  wire logic [2:0] oeN,
    // Resolved line levels
    output logic      [2:0] pinWire
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] lastQ;

    // A released line must not look like a held value.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pinWire[i] = oeN[i] ? ~lastQ[i] : level[i];
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (!oeN[i]) begin
                lastQ[i] <= level[i];
            end
        end
    end
endmodule

// ===== verif/test_cd_servo_status_pin_outputs.sv
// Purpose: Self-checking bench for the servo, status and command pins.
// Assumes: Short subsystem clock division so the divider is seen quickly.
// Notes:   Outputs follow sampled inputs one enabled edge later.
module test_cd_servo_status_pin_outputs;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DIV = 8;

    logic                         clk = 1'b0;
    logic                         sys_rst = 1'b1;
    logic                         ce = 1'b1;
    logic                         processorResetN = 1'b1;
    logic                         tunerResetN = 1'b1;
    logic                         discIsRw = 1'b0;
    logic                         syncDetected = 1'b0;
    logic                         syncInternal = 1'b0;
    cssp_pkg::cssp_drive_req_type spindleReq = '0;
    cssp_pkg::cssp_jump_req_type  jumpReq = '0;
    logic                         trackingOn = 1'b0;
    logic                         gainIncrease = 1'b0;
    cssp_pkg::cssp_sled_type      sledReq = '0;
    cssp_pkg::cssp_cmd_type       cmdReq = '0;
    logic                         driverMuteReq = 1'b0;
    logic                         audioMuteReq = 1'b0;
    logic                         subsysClk;
    logic                         rewritableDiscIndN;
    logic                         frameSyncMatch;
    logic                         spindleDrive;
    logic                         spindleDriveOeN;
    logic                         trackJumpDrive;
    logic                         trackJumpDriveOeN;
    logic                         trackingDisable;
    logic                         trackingDisableOeN;
    logic                         trackingGainSelect;
    cssp_pkg::cssp_sled_type      sledFeed;
    cssp_pkg::cssp_cmd_type       cmdOut;
    logic                         driverMuteN;
    logic                         audioMuteN;
    logic [2:0]                   pinWire;
    int                           fails = 0;
    int                           num_checks = 0;

    always #4 clk = ~clk;

    cssp_top #(.SUBCLK_DIV(DIV)) uut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .processorResetN(processorResetN), .tunerResetN(tunerResetN),
        .discIsRw(discIsRw), .syncDetected(syncDetected),
        .syncInternal(syncInternal), .spindleReq(spindleReq),
        .jumpReq(jumpReq), .trackingOn(trackingOn),
        .gainIncrease(gainIncrease), .sledReq(sledReq), .cmdReq(cmdReq),
        .driverMuteReq(driverMuteReq), .audioMuteReq(audioMuteReq),
        .subsysClk(subsysClk), .rewritableDiscIndN(rewritableDiscIndN),
        .frameSyncMatch(frameSyncMatch), .spindleDrive(spindleDrive),
        .spindleDriveOeN(spindleDriveOeN), .trackJumpDrive(trackJumpDrive),
        .trackJumpDriveOeN(trackJumpDriveOeN),
        .trackingDisable(trackingDisable),
        .trackingDisableOeN(trackingDisableOeN),
        .trackingGainSelect(trackingGainSelect), .sledFeed(sledFeed),
        .cmdOut(cmdOut), .driverMuteN(driverMuteN), .audioMuteN(audioMuteN)
    );

    cssp_servo_model servoModel (
        .clk(clk),
        .level({spindleDrive, trackJumpDrive, trackingDisable}),
        .oeN({spindleDriveOeN, trackJumpDriveOeN, trackingDisableOeN}),
        .pinWire(pinWire)
    );

    // Pin code: 2 floating, 1 driven high, 0 driven low.
    function automatic logic [3:0] pin(input logic oeN, input logic w);
        return {2'h0, oeN, oeN ? 1'b0 : w};
    endfunction

    task automatic chk(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic end_sim;
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic t_reset_state;
        chk("rwind", 4'h0, {3'h0, rewritableDiscIndN});
        chk("sync", 4'h0, {3'h0, frameSyncMatch});
        chk("spindle", 4'h2, pin(spindleDriveOeN, pinWire[2]));
        chk("jump", 4'h2, pin(trackJumpDriveOeN, pinWire[1]));
        chk("track", 4'h2, pin(trackingDisableOeN, pinWire[0]));
        chk("cmd", 4'h3, {1'b0, cmdOut});
        chk("sled", 4'h0, {2'h0, sledFeed});
        chk("drvmute", 4'h0, {3'h0, driverMuteN});
    endtask

    task automatic t_spindle_tuner_low;
        @(posedge clk);
        tunerResetN <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            spindleReq <= cssp_pkg::cssp_drive_req_type'(i[1:0]);
            step();
            chk("spindle", (i == 1 || i == 2) ? 4'(i[1]) : 4'h2,
                pin(spindleDriveOeN, pinWire[2]));
        end
        @(posedge clk);
        tunerResetN <= 1'b1;
    endtask

    task automatic t_jump;
        logic a;
        logic d;
        logic o;
        for (int i = 0; i < 8; i++) begin
            {a, d, o} = i[2:0];
            @(posedge clk);
            jumpReq <= cssp_pkg::cssp_jump_req_type'(i[2:0]);
            step();
            chk("jump", (a == d) ? 4'h2 : {3'h0, (a & o) | (d & ~o)},
                pin(trackJumpDriveOeN, pinWire[1]));
        end
    endtask

    task automatic t_status;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            syncDetected <= i[1];
            syncInternal <= i[0];
            discIsRw <= i[0];
            trackingOn <= i[1];
            gainIncrease <= i[0];
            step();
            chk("sync", {3'h0, i == 3}, {3'h0, frameSyncMatch});
            chk("rwind", {3'h0, ~i[0]}, {3'h0, rewritableDiscIndN});
            chk("track", {3'h0, ~i[1]},
                pin(trackingDisableOeN, pinWire[0]));
            chk("gain", {3'h0, ~i[0]}, {3'h0, trackingGainSelect});
        end
    endtask

    task automatic t_subclk;
        int n;
        int hi;
        int rises;
        logic prev;
        n = 0;
        while (subsysClk !== 1'b0 && n < 100) begin
            step();
            n++;
        end
        while (subsysClk !== 1'b1 && n < 100) begin
            step();
            n++;
        end
        hi = 0;
        rises = 0;
        prev = 1'b1;
        repeat (2 * DIV) begin
            step();
            hi += int'(subsysClk === 1'b1);
            rises += int'(subsysClk === 1'b1 && prev === 1'b0);
            prev = subsysClk;
        end
        chk("subclk_high", 4'(DIV), 4'(hi));
        chk("subclk_rises", 4'h2, 4'(rises));
    endtask

    task automatic t_proc_reset;
        @(posedge clk);
        syncDetected <= 1'b1;
        syncInternal <= 1'b1;
        discIsRw <= 1'b0;
        spindleReq <= 2'h2;
        jumpReq <= 3'h5;
        trackingOn <= 1'b1;
        gainIncrease <= 1'b1;
        sledReq <= 2'h3;
        cmdReq <= 3'h4;
        driverMuteReq <= 1'b0;
        audioMuteReq <= 1'b0;
        step();
        chk("cmd", 4'h4, {1'b0, cmdOut});
        chk("sled", 4'h3, {2'h0, sledFeed});
        chk("drvmute", 4'h1, {3'h0, driverMuteN});
        chk("audmute", 4'h1, {3'h0, audioMuteN});
        @(posedge clk);
        processorResetN <= 1'b0;
        step();
        t_reset_state();
        chk("audmute", 4'h1, {3'h0, audioMuteN});
        @(posedge clk);
        audioMuteReq <= 1'b1;
        step();
        chk("audmute", 4'h0, {3'h0, audioMuteN});
        t_subclk();
        @(posedge clk);
        processorResetN <= 1'b1;
        driverMuteReq <= 1'b1;
        step();
        chk("drvmute", 4'h0, {3'h0, driverMuteN});
        chk("cmd", 4'h4, {1'b0, cmdOut});
        chk("sled", 4'h3, {2'h0, sledFeed});
    endtask

    task automatic t_freeze;
        @(posedge clk);
        spindleReq <= 2'h2;
        step();
        @(posedge clk);
        ce <= 1'b0;
        spindleReq <= 2'h1;
        step();
        step();
        chk("spindle", 4'h1, pin(spindleDriveOeN, pinWire[2]));
        @(posedge clk);
        ce <= 1'b1;
        step();
        chk("spindle", 4'h0, pin(spindleDriveOeN, pinWire[2]));
    endtask

    initial begin
        step();
        t_reset_state();
        chk("subclk", 4'h0, {3'h0, subsysClk});
        chk("gain", 4'h1, {3'h0, trackingGainSelect});
        chk("audmute", 4'h0, {3'h0, audioMuteN});
        @(posedge clk);
        sys_rst <= 1'b0;
        t_subclk();
        t_spindle_tuner_low();
        t_jump();
        t_status();
        t_proc_reset();
        t_freeze();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_sim();
    end
endmodule
